// >>> cfd_config_fuse_decoder.v
// Configuration cell bank with power-up latching decoder.
// Assumes a plain register port on mclk_i; cells are programmed through it by the programmer.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`include "cfd_map.vh"

module cfd_config_fuse_decoder #(
  parameter [1:0] TECH_DEFAULT = `CFD_TECH_FLASH
) (
  input  wire        mclk_i,
  input  wire        rst_b_i,
  input  wire        clk_en_i,
  // Register port
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  // Table read
  input  wire [31:0] tbl_addr_i,
  input  wire        tbl_rd_i,
  output reg  [31:0] rdata_o,
  output reg  [7:0]  tbl_data_o,
  // Latch status and decoded selections
  output reg         cfg_ready_o,
  output reg         upper_addr_drv_off_o,
  output reg         mid_ad_drv_off_o,
  output reg         low_ad_drv_off_o,
  output reg         byte_addr_drv_off_o,
  output reg         byte_sel_drv_off_o,
  output reg         write_strobe_drv_off_o,
  output reg         brownout_rst_en_o,
  output reg  [1:0]  brownout_level_sel_o,
  output reg         bus_width_sel_o,
  output reg         capcmp2_pin_route_o,
  output reg         prog_protect_o,
  output reg         data_mem_protect_o,
  output reg  [2:0]  osc_type_sel_o,
  output reg         osc2_is_io_o,
  output reg         pll_en_o,
  output reg         clk_switch_lock_o,
  output reg  [1:0]  proc_mode_sel_o,
  output reg         powerup_timer_en_o,
  output reg         stack_fault_rst_en_o,
  output reg  [1:0]  wait_states_o,
  output reg  [7:0]  wd_postscale_ratio_o,
  output reg         wd_run_o,
  output reg         osc_startup_en_o,
  output reg  [10:0] osc_startup_cycles_o,
  output reg         prog_mem_erase_o
);

  // ****************************************************************
  // Cell word layout (one = erased, zero = programmed)
  // ****************************************************************
  // Bit 0      Upper address drivers kept on
  // Bit 1      Mid address/data drivers kept on, 8-bit bus only
  // Bit 2      Low address/data drivers kept on, 8-bit bus only
  // Bit 3      Byte address line driver kept on
  // Bit 4      Upper and lower byte select drivers kept on
  // Bit 5      High and low write strobe drivers kept on
  // Bit 6      Brown-out reset enabled
  // Bits 8:7   Brown-out trip level
  // Bit 9      Bus width, one for 16-bit data
  // Bit 10     Second capture/compare unit on its default pin
  // Bit 11     Program memory unprotected
  // Bit 12     Data memory unprotected
  // Bits 15:13 Oscillator type
  // Bit 16     Clock locked to the main oscillator
  // Bits 18:17 Processor mode
  // Bit 19     Power-up timer disabled
  // Bit 20     Stack fault causes reset
  // Bit 21     External bus never waits
  // Bits 24:22 Watchdog postscale
  // Bit 25     Watchdog forced on
  // Bits 31:26 Spare, read back as stored

  // ****************************************************************
  // Register port map
  // ****************************************************************
  // Index 0  Cell word read, program data stage write
  // Index 2  Cell technology select
  // Index 3  Program or erase command, reads staged data
  // Index 4  Latch done flag
  // Index 5  Latched cell image
  // Index 7  Software watchdog enable
  // Index 8  External bus wait count
  // Other    Read zero, writes dropped
  // Read data stand one cycle after the read strobe, else zero
  // Table reads give cell byte 0 at the base, little-endian

  // ****************************************************************
  // Derived selections
  // ****************************************************************
  // Second oscillator pin is general I/O for the RC and EC types
  // that carry the I/O suffix; the PLL runs only for HS with PLL.
  // Wait states come from the software count unless the cell says
  // the bus never waits. The watchdog runs when the cell forces it
  // or software has set its enable. The postscale output is the
  // division ratio as a one-hot value, 1 for code 7 up to 128 for 0.
  // The start-up count applies to LP, XT, HS and HS with PLL only.

  // ****************************************************************
  // Limits
  // ****************************************************************
  // Cells hold no reset value: a power-on image is unknown until the
  // programmer erases it, so erase before the first latch.
  // The technology select stands in for the part's memory type and
  // would be fixed in silicon; software may change it here.
  // Writes to unmapped indices are dropped without notice.

  // ****************************************************************
  // Cell bank and control state
  // ****************************************************************
  reg [31:0] cells;
  reg [31:0] prog_data;
  reg [1:0]  tech;
  reg        software_wd_enable;
  reg [1:0]  mem_wait;
  reg [3:0]  load_cnt;
  reg        loaded;
  reg [31:0] active;
  reg [31:0] next_cells;
  reg [31:0] next_rdata;
  reg [7:0]  next_tbl;
  wire       is_xtal;
  wire       sel_8bit;
  wire [2:0] ps;

  // ****************************************************************
  // Programming path
  // ****************************************************************
  // Programming only clears bits; only erase sets them, and only on
  // technologies that allow it. A ROM bank ignores both commands.
  always @* begin
    next_cells = cells;
    if (wr_i && addr_i == `CFD_REG_PROG) begin
      case (tech)
        `CFD_TECH_OTP: begin
          if (wdata_i[1:0] == `CFD_OP_PROG)
            next_cells = cells & prog_data;
        end
        `CFD_TECH_UV: begin
          if (wdata_i[1:0] == `CFD_OP_PROG)
            next_cells = cells & prog_data;
          else if (wdata_i[1:0] == `CFD_OP_ERASE)
            next_cells = `CFD_ERASED;
        end
        `CFD_TECH_FLASH: begin
          if (wdata_i[1:0] == `CFD_OP_PROG)
            next_cells = cells & prog_data;
          else if (wdata_i[1:0] == `CFD_OP_ERASE)
            next_cells = `CFD_ERASED;
        end
        default: next_cells = cells;
      endcase
    end
  end

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tech               <= TECH_DEFAULT;
      prog_data          <= `CFD_ERASED;
      software_wd_enable <= 1'b0;
      mem_wait           <= 2'h0;
      prog_mem_erase_o   <= 1'b0;
    end else if (clk_en_i) begin
      // One-cycle pulse: the program memory is wiped with the cells
      // only on a window-erasable bank
      prog_mem_erase_o <= wr_i && addr_i == `CFD_REG_PROG && tech == `CFD_TECH_UV &&
                          wdata_i[1:0] == `CFD_OP_ERASE;
      if (wr_i && addr_i == `CFD_REG_CFG_LO)
        prog_data <= wdata_i;
      if (wr_i && addr_i == `CFD_REG_CTRL)
        tech <= wdata_i[`CFD_CTRL_TECH+1:`CFD_CTRL_TECH];
      if (wr_i && addr_i == `CFD_REG_WD_CTRL)
        software_wd_enable <= wdata_i[0];
      if (wr_i && addr_i == `CFD_REG_MEM_CTRL)
        mem_wait <= wdata_i[1:0];
    end
  end

  // Cells are nonvolatile: only programming changes them, reset does not
  always @(posedge mclk_i) begin
    if (clk_en_i)
      cells <= next_cells;
  end

  // ****************************************************************
  // Power-up latch of cell image
  // ****************************************************************
  // The image is taken a few enabled edges after reset, so a programmer
  // may erase cells of unknown power-on state first. Decoded outputs
  // follow one edge later, and the ready flag rises on that same edge.
  // Reprogrammed cells reach the outputs only after the next reset.
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_cnt <= 4'h0;
      loaded   <= 1'b0;
      active   <= `CFD_ERASED;
    end else if (clk_en_i && !loaded) begin
      load_cnt <= load_cnt + 4'h1;
      if (load_cnt == `CFD_LOAD_CYCLES) begin
        active <= cells;
        loaded <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Crystal and resonator types need the start-up timer
  assign ps       = active[`CFD_B_WD_PS+2:`CFD_B_WD_PS];
  assign sel_8bit = ~active[`CFD_B_BUS_WIDTH];
  assign is_xtal  = active[`CFD_B_OSC+2:`CFD_B_OSC] == `CFD_OSC_LP ||
                    active[`CFD_B_OSC+2:`CFD_B_OSC] == `CFD_OSC_XT ||
                    active[`CFD_B_OSC+2:`CFD_B_OSC] == `CFD_OSC_HS ||
                    active[`CFD_B_OSC+2:`CFD_B_OSC] == `CFD_OSC_HSPLL;

  // Reset shows safe selections, then an erased image until the latch: drivers
  // on, protection off, ready low; watchdog idle in reset, forced on after.
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_ready_o            <= 1'b0;
      upper_addr_drv_off_o   <= 1'b0;
      mid_ad_drv_off_o       <= 1'b0;
      low_ad_drv_off_o       <= 1'b0;
      byte_addr_drv_off_o    <= 1'b0;
      byte_sel_drv_off_o     <= 1'b0;
      write_strobe_drv_off_o <= 1'b0;
      brownout_rst_en_o      <= 1'b0;
      brownout_level_sel_o   <= `CFD_BOR_LOW;
      bus_width_sel_o        <= 1'b1;
      capcmp2_pin_route_o    <= 1'b1;
      prog_protect_o         <= 1'b0;
      data_mem_protect_o     <= 1'b0;
      osc_type_sel_o         <= `CFD_OSC_RCIO;
      osc2_is_io_o           <= 1'b0;
      pll_en_o               <= 1'b0;
      clk_switch_lock_o      <= 1'b1;
      proc_mode_sel_o        <= `CFD_PM_MPU;
      powerup_timer_en_o     <= 1'b0;
      stack_fault_rst_en_o   <= 1'b0;
      wait_states_o          <= 2'h0;
      wd_postscale_ratio_o   <= 8'h01;
      wd_run_o               <= 1'b0;
      osc_startup_en_o       <= 1'b0;
      osc_startup_cycles_o   <= 11'h000;
    end else if (clk_en_i) begin
      cfg_ready_o            <= loaded;
      upper_addr_drv_off_o   <= ~active[`CFD_B_UPPER_ADDR];
      mid_ad_drv_off_o       <= sel_8bit & ~active[`CFD_B_MID_AD];
      low_ad_drv_off_o       <= sel_8bit & ~active[`CFD_B_LOW_AD];
      byte_addr_drv_off_o    <= ~active[`CFD_B_BYTE_ADDR];
      byte_sel_drv_off_o     <= ~active[`CFD_B_BYTE_SEL];
      write_strobe_drv_off_o <= ~active[`CFD_B_WRITE_STB];
      brownout_rst_en_o      <= active[`CFD_B_BOR_EN];
      brownout_level_sel_o   <= active[`CFD_B_BOR_LVL+1:`CFD_B_BOR_LVL];
      bus_width_sel_o        <= active[`CFD_B_BUS_WIDTH];
      capcmp2_pin_route_o    <= active[`CFD_B_CAPCMP2];
      prog_protect_o         <= ~active[`CFD_B_PROG_PROT];
      data_mem_protect_o     <= ~active[`CFD_B_DATA_PROT];
      osc_type_sel_o         <= active[`CFD_B_OSC+2:`CFD_B_OSC];
      osc2_is_io_o           <= active[`CFD_B_OSC+2:`CFD_B_OSC] == `CFD_OSC_RCIO ||
                                active[`CFD_B_OSC+2:`CFD_B_OSC] == `CFD_OSC_ECIO;
      pll_en_o               <= active[`CFD_B_OSC+2:`CFD_B_OSC] == `CFD_OSC_HSPLL;
      clk_switch_lock_o      <= active[`CFD_B_CLK_LOCK];
      proc_mode_sel_o        <= active[`CFD_B_PMODE+1:`CFD_B_PMODE];
      powerup_timer_en_o     <= ~active[`CFD_B_POWERUP_DELAY_TIMER_N];
      stack_fault_rst_en_o   <= active[`CFD_B_STK_RST];
      wait_states_o          <= active[`CFD_B_BUS_WAIT] ? 2'h0 : mem_wait;
      wd_postscale_ratio_o   <= 8'h80 >> ps;
      wd_run_o               <= active[`CFD_B_WD_FORCE] | software_wd_enable;
      osc_startup_en_o       <= is_xtal;
      osc_startup_cycles_o   <= is_xtal ? `CFD_OST_CYCLES : 11'h000;
    end
  end

  // ****************************************************************
  // Register and table read
  // ****************************************************************
  always @* begin
    case (addr_i)
      `CFD_REG_CFG_LO:    next_rdata = cells;
      `CFD_REG_CTRL:      next_rdata = {30'h0, tech};
      `CFD_REG_PROG:      next_rdata = prog_data;
      `CFD_REG_STAT:      next_rdata = {31'h0, loaded};
      `CFD_REG_ACTIVE_LO: next_rdata = active;
      `CFD_REG_WD_CTRL:   next_rdata = {31'h0, software_wd_enable};
      `CFD_REG_MEM_CTRL:  next_rdata = {30'h0, mem_wait};
      default:            next_rdata = 32'h0000_0000;
    endcase
  end

  // Table read byte select
  always @* begin
    case (tbl_addr_i)
      `CFD_CFG_BASE:          next_tbl = cells[7:0];
      `CFD_CFG_BASE + 32'h1:  next_tbl = cells[15:8];
      `CFD_CFG_BASE + 32'h2:  next_tbl = cells[23:16];
      `CFD_CFG_BASE + 32'h3:  next_tbl = cells[31:24];
      default:                next_tbl = 8'h00;
    endcase
  end

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o    <= 32'h0000_0000;
      tbl_data_o <= 8'h00;
    end else if (clk_en_i) begin
      rdata_o    <= rd_i ? next_rdata : 32'h0000_0000;
      tbl_data_o <= tbl_rd_i ? next_tbl : 8'h00;
    end
  end

endmodule // cfd_config_fuse_decoder

// >>> cfd_map.vh
// Offsets, field positions, reset values and timing counts for the configuration decoder.
// Assumes a 125 MHz core clock and table-read access to the configuration cells.
`ifndef CFD_MAP_VH
`define CFD_MAP_VH

// ****************************************************************
// Register map (plain port, word index)
// ****************************************************************
`define CFD_CFG_BASE        32'h0030_0000
`define CFD_REG_CFG_LO      4'h0
`define CFD_REG_CFG_HI      4'h1
`define CFD_REG_CTRL        4'h2
`define CFD_REG_PROG        4'h3
`define CFD_REG_STAT        4'h4
`define CFD_REG_ACTIVE_LO   4'h5
`define CFD_REG_ACTIVE_HI   4'h6
`define CFD_REG_WD_CTRL     4'h7
`define CFD_REG_MEM_CTRL    4'h8

// ****************************************************************
// Cell positions in the 32-bit cell word
// ****************************************************************
`define CFD_B_UPPER_ADDR    0
`define CFD_B_MID_AD        1
`define CFD_B_LOW_AD        2
`define CFD_B_BYTE_ADDR     3
`define CFD_B_BYTE_SEL      4
`define CFD_B_WRITE_STB     5
`define CFD_B_BOR_EN        6
`define CFD_B_BOR_LVL       7
`define CFD_B_BUS_WIDTH     9
`define CFD_B_CAPCMP2       10
`define CFD_B_PROG_PROT     11
`define CFD_B_DATA_PROT     12
`define CFD_B_OSC           13
`define CFD_B_CLK_LOCK      16
`define CFD_B_PMODE         17
`define CFD_B_POWERUP_DELAY_TIMER_N        19
`define CFD_B_STK_RST       20
`define CFD_B_BUS_WAIT      21
`define CFD_B_WD_PS         22
`define CFD_B_WD_FORCE      25
`define CFD_CELL_W          26

// ****************************************************************
// Technology, control and encodings
// ****************************************************************
`define CFD_TECH_ROM        2'h0
`define CFD_TECH_OTP        2'h1
`define CFD_TECH_UV         2'h2
`define CFD_TECH_FLASH      2'h3
`define CFD_CTRL_TECH       0
`define CFD_CTRL_SWDT       2
`define CFD_OP_PROG         2'h1
`define CFD_OP_ERASE        2'h2
`define CFD_ERASED          32'hFFFF_FFFF
`define CFD_OSC_RCIO        3'h7
`define CFD_OSC_HSPLL       3'h6
`define CFD_OSC_ECIO        3'h5
`define CFD_OSC_EC          3'h4
`define CFD_OSC_RC          3'h3
`define CFD_OSC_HS          3'h2
`define CFD_OSC_XT          3'h1
`define CFD_OSC_LP          3'h0
`define CFD_BOR_LOW         2'h3
`define CFD_BOR_2V7         2'h2
`define CFD_BOR_4V2         2'h1
`define CFD_BOR_4V5         2'h0
`define CFD_PM_MPU          2'h3
`define CFD_PM_MCU          2'h2
`define CFD_PM_RSVD         2'h1
`define CFD_PM_XMCU         2'h0
`define CFD_OST_CYCLES      11'h400
`define CFD_LOAD_CYCLES     4'h4
`endif

// >>> cfd_checker_props.sv
// Concurrent checks on the configuration decoder's top-level ports.
// Assumes one clock mclk_i and the asynchronous active-low reset rst_b_i.
module cfd_checker (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        rd_i,
  input wire logic        tbl_rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [7:0]  tbl_data_o,
  input wire logic        cfg_ready_o,
  input wire logic        mid_ad_drv_off_o,
  input wire logic        low_ad_drv_off_o,
  input wire logic        bus_width_sel_o,
  input wire logic [2:0]  osc_type_sel_o,
  input wire logic        osc2_is_io_o,
  input wire logic        pll_en_o,
  input wire logic        osc_startup_en_o,
  input wire logic [10:0] osc_startup_cycles_o,
  input wire logic [7:0]  wd_postscale_ratio_o,
  input wire logic [1:0]  proc_mode_sel_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_mid_ad_width: assert property (mid_ad_drv_off_o |-> !bus_width_sel_o)
    else $error("mid AD drivers off in 16-bit mode");
  a_low_ad_width: assert property (low_ad_drv_off_o |-> !bus_width_sel_o)
    else $error("low AD drivers off in 16-bit mode");
  a_osc_io_pin: assert property (cfg_ready_o |-> osc2_is_io_o ==
    (osc_type_sel_o == 3'h7 || osc_type_sel_o == 3'h5)) else $error("osc pin mode mismatch");
  a_pll_decode: assert property (cfg_ready_o |-> pll_en_o == (osc_type_sel_o == 3'h6))
    else $error("pll enable mismatch");
  a_ost_select: assert property (cfg_ready_o |-> osc_startup_en_o ==
    (osc_type_sel_o inside {3'h0, 3'h1, 3'h2, 3'h6})) else $error("start-up timer select wrong");
  a_ost_count: assert property (osc_startup_cycles_o == (osc_startup_en_o ? 11'h400 : 11'h000))
    else $error("start-up count wrong");
  a_ratio_onehot: assert property (cfg_ready_o |-> $onehot(wd_postscale_ratio_o))
    else $error("postscale ratio not a power of two");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  a_tbl_idle: assert property (!$past(tbl_rd_i) |-> tbl_data_o == 8'h0)
    else $error("table data outside its cycle");
  a_ready_hold: assert property (cfg_ready_o |=> cfg_ready_o)
    else $error("ready dropped without reset");
  a_cfg_hold: assert property (cfg_ready_o && $past(cfg_ready_o) |-> $stable(osc_type_sel_o)
    && $stable(proc_mode_sel_o) && $stable(bus_width_sel_o)) else $error("decoded mode moved");
  c_read: cover property (rd_i ##1 rdata_o != 32'h0);
  c_latch: cover property ($rose(cfg_ready_o));
  c_pll: cover property (cfg_ready_o && pll_en_o);
endmodule // cfd_checker

bind cfd_config_fuse_decoder cfd_checker u_cfd_checker (.mclk_i, .rst_b_i, .rd_i, .tbl_rd_i,
  .rdata_o, .tbl_data_o, .cfg_ready_o, .mid_ad_drv_off_o, .low_ad_drv_off_o, .bus_width_sel_o,
  .osc_type_sel_o, .osc2_is_io_o, .pll_en_o, .osc_startup_en_o, .osc_startup_cycles_o,
  .wd_postscale_ratio_o, .proc_mode_sel_o);

// >>> cfd_programmer.sv
// Device programmer model driving the cell bank over the register port.
// Assumes the decoder answers reads one cycle after the strobe, never stalling.
module cfd_programmer (
  input  wire logic        mclk_i,
  input  wire logic [31:0] rdata_i,
  output logic      [3:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 4'h0;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    // Released data no longer carries the last word
    wdata_o <= ~d;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule // cfd_programmer

// >>> tb_top.sv
// Self-checking bench for the configuration decoder.
// Assumes cfd_map.vh encodings and a flash cell bank out of reset.
`include "cfd_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        clk_en_i = 1'b1;
  logic [31:0] tbl_addr_i = 32'h0;
  logic        tbl_rd_i = 1'b0;
  wire  [3:0]  addr_i;
  wire  [31:0] wdata_i, rdata_o;
  wire         wr_i, rd_i, cfg_ready_o, prog_mem_erase_o;
  wire  [7:0]  tbl_data_o, wd_postscale_ratio_o;
  wire  [1:0]  brownout_level_sel_o, proc_mode_sel_o, wait_states_o;
  wire  [2:0]  osc_type_sel_o;
  wire  [10:0] osc_startup_cycles_o;
  wire         upper_addr_drv_off_o, mid_ad_drv_off_o, low_ad_drv_off_o, byte_addr_drv_off_o;
  wire         byte_sel_drv_off_o, write_strobe_drv_off_o, brownout_rst_en_o, bus_width_sel_o;
  wire         capcmp2_pin_route_o, prog_protect_o, data_mem_protect_o, osc2_is_io_o, pll_en_o;
  wire         clk_switch_lock_o, powerup_timer_en_o, stack_fault_rst_en_o, wd_run_o;
  wire         osc_startup_en_o;
  int          errors = 0, cmp_count = 0;
  logic [31:0] d, p, q;
  logic [7:0]  b;
  logic        seen;
  always #4 mclk_i = ~mclk_i;
  cfd_programmer u_cfd_programmer (.mclk_i, .rdata_i(rdata_o), .addr_o(addr_i),
    .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  cfd_config_fuse_decoder u_cfd_config_fuse_decoder (.mclk_i, .rst_b_i, .clk_en_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .tbl_addr_i, .tbl_rd_i, .rdata_o, .tbl_data_o, .cfg_ready_o,
    .upper_addr_drv_off_o, .mid_ad_drv_off_o, .low_ad_drv_off_o, .byte_addr_drv_off_o,
    .byte_sel_drv_off_o, .write_strobe_drv_off_o, .brownout_rst_en_o, .brownout_level_sel_o,
    .bus_width_sel_o, .capcmp2_pin_route_o, .prog_protect_o, .data_mem_protect_o,
    .osc_type_sel_o, .osc2_is_io_o, .pll_en_o, .clk_switch_lock_o, .proc_mode_sel_o,
    .powerup_timer_en_o, .stack_fault_rst_en_o, .wait_states_o, .wd_postscale_ratio_o,
    .wd_run_o, .osc_startup_en_o, .osc_startup_cycles_o, .prog_mem_erase_o);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic results();
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    u_cfd_programmer.bus_wr(a, v);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    u_cfd_programmer.bus_rd(a, v);
  endtask
  task automatic tbl(input logic [1:0] i, output logic [7:0] v);
    @(posedge mclk_i);
    tbl_addr_i <= `CFD_CFG_BASE + {30'h0, i};
    tbl_rd_i <= 1'b1;
    @(posedge mclk_i);
    tbl_rd_i <= 1'b0;
    #1;
    v = tbl_data_o;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic do_reset();
    int n;
    rst_b_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    n = 0;
    while (cfg_ready_o !== 1'b1 && n < 30) begin
      @(posedge mclk_i);
      n++;
    end
    if (cfg_ready_o !== 1'b1) begin
      errors++;
      results();
    end
    #1;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    rst_b_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    // Erase before the first latch so no unknown cells get decoded
    wr(`CFD_REG_PROG, {30'h0, `CFD_OP_ERASE});
    settle(10);
    rd(`CFD_REG_CFG_LO, q);
    chk("erased cells", `CFD_ERASED, q);
    for (int i = 0; i < 4; i++) begin
      tbl(i[1:0], b);
      chk("table byte", 32'hFF, b);
    end
    p = `CFD_ERASED;
    for (int i = 0; i < 8; i++) begin
      d = 32'h5A3C_96E1 ^ {8{i[3:0]}};
      d[15:13] = i[2:0];
      d[24:22] = i[2:0];
      d[8:7] = i[1:0];
      d[18:17] = i[1:0];
      d[9] = i[0];
      wr(`CFD_REG_PROG, {30'h0, `CFD_OP_ERASE});
      wr(`CFD_REG_CFG_LO, d);
      wr(`CFD_REG_PROG, {30'h0, `CFD_OP_PROG});
      rd(`CFD_REG_CFG_LO, q);
      chk("cells", d, q);
      tbl(i[1:0], b);
      chk("table", d[8*(i%4) +: 8], b);
      chk("osc held", p[15:13], osc_type_sel_o);
      do_reset();
      wr(`CFD_REG_MEM_CTRL, {30'h0, i[1:0]});
      wr(`CFD_REG_WD_CTRL, 32'h0);
      settle(2);
      chk("upper drv", !d[0], upper_addr_drv_off_o);
      chk("mid drv", !d[9] && !d[1], mid_ad_drv_off_o);
      chk("low drv", !d[9] && !d[2], low_ad_drv_off_o);
      chk("byte addr drv", !d[3], byte_addr_drv_off_o);
      chk("byte sel drv", !d[4], byte_sel_drv_off_o);
      chk("strobe drv", !d[5], write_strobe_drv_off_o);
      chk("bor en", d[6], brownout_rst_en_o);
      chk("bor level", d[8:7], brownout_level_sel_o);
      chk("bus width", d[9], bus_width_sel_o);
      chk("pin route", d[10], capcmp2_pin_route_o);
      chk("prog prot", !d[11], prog_protect_o);
      chk("data prot", !d[12], data_mem_protect_o);
      chk("osc", i[2:0], osc_type_sel_o);
      chk("osc io", i == 7 || i == 5, osc2_is_io_o);
      chk("pll", i == 6, pll_en_o);
      chk("clk lock", d[16], clk_switch_lock_o);
      chk("proc mode", d[18:17], proc_mode_sel_o);
      chk("powerup_delay_timer", !d[19], powerup_timer_en_o);
      chk("stack rst", d[20], stack_fault_rst_en_o);
      chk("wait", d[21] ? 2'h0 : i[1:0], wait_states_o);
      chk("ratio", 8'h80 >> i[2:0], wd_postscale_ratio_o);
      chk("wd run", d[25], wd_run_o);
      chk("ost en", i < 3 || i == 6, osc_startup_en_o);
      chk("ost cycles", (i < 3 || i == 6) ? 11'h400 : 11'h0, osc_startup_cycles_o);
      wr(`CFD_REG_WD_CTRL, 32'h1);
      settle(2);
      chk("wd soft run", 1'b1, wd_run_o);
      p = d;
    end
    rd(`CFD_REG_STAT, q);
    chk("stat", 32'h1, q);
    rd(`CFD_REG_ACTIVE_LO, q);
    chk("active", d, q);
    wr(`CFD_REG_CTRL, {30'h0, `CFD_TECH_ROM});
    rd(`CFD_REG_CTRL, q);
    chk("tech", {30'h0, `CFD_TECH_ROM}, q);
    wr(`CFD_REG_CFG_LO, 32'h0);
    wr(`CFD_REG_PROG, {30'h0, `CFD_OP_PROG});
    rd(`CFD_REG_CFG_LO, q);
    chk("rom cells", d, q);
    wr(`CFD_REG_CTRL, {30'h0, `CFD_TECH_OTP});
    wr(`CFD_REG_PROG, {30'h0, `CFD_OP_ERASE});
    wr(`CFD_REG_CFG_LO, 32'hFFFF_FF00);
    wr(`CFD_REG_PROG, {30'h0, `CFD_OP_PROG});
    rd(`CFD_REG_CFG_LO, q);
    chk("otp cells", d & 32'hFFFF_FF00, q);
    wr(`CFD_REG_CTRL, {30'h0, `CFD_TECH_UV});
    wr(`CFD_REG_PROG, {30'h0, `CFD_OP_ERASE});
    seen = 1'b0;
    repeat (4) begin
      #1;
      seen = seen | (prog_mem_erase_o === 1'b1);
      @(posedge mclk_i);
    end
    chk("program erase", 1'b1, seen);
    rd(`CFD_REG_CFG_LO, q);
    chk("uv cells", `CFD_ERASED, q);
    @(posedge mclk_i);
    clk_en_i <= 1'b0;
    wr(`CFD_REG_CFG_LO, 32'h0);
    wr(`CFD_REG_PROG, {30'h0, `CFD_OP_PROG});
    clk_en_i <= 1'b1;
    rd(`CFD_REG_CFG_LO, q);
    chk("frozen cells", `CFD_ERASED, q);
    rd(4'hF, q);
    chk("unmapped", 32'h0, q);
    results();
  end
endmodule // tb_top
